/* logic/ffu_seq.sv */
// firmware update sequencer of the serial register target
// assumes the serial framing is decoded outside into one-cycle register strobes
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ffu_seq #(
   parameter int unsigned BOOT_CYCLES  = ffu_pkg::BOOT_CYC,
   parameter int unsigned ERASE_CYCLES = ffu_pkg::ERASE_CYC,
   parameter int unsigned APP_BYTES    = ffu_pkg::APP_BYTES_DEF
) (
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic [3:0] addr_strap_pins_in,
   input  wire logic [6:0] dev_addr_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   output logic            ack_out,
   output logic            loader_out,
   output logic            busy_out,
   output logic            fail_out
);
   import ffu_pkg::*;
   localparam int AW = $clog2(APP_BYTES);
   // check pass length: one read per byte, one pipeline stage, one closing cycle
   localparam int CRC_LEN = int'(APP_BYTES) + 2;

   ffu_flash_if #(.AW(AW)) fl ();
   ffu_flash #(.DEPTH(APP_BYTES), .AW(AW)) u_flash (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .fl        (fl)
   );

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
      end
      return x;
   endfunction

   // ----------------------------------------------------------------
   // strap pins: three stages, accept when last two agree
   // ----------------------------------------------------------------
   logic [3:0] s1_r, s2_r, s3_r, strap_r, strap_nxt;
   always_comb begin
      strap_nxt = (s2_r == s3_r) ? s3_r : strap_r;
   end
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         strap_r <= '0;
      end else begin
         s1_r    <= addr_strap_pins_in;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         strap_r <= strap_nxt;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   ffu_state_t  st_r, st_nxt;
   logic [31:0] tmr_r, tmr_nxt;
   logic        key_r, key_nxt;
   logic        fail_r, fail_nxt;
   logic [15:0] faddr_r, faddr_nxt;
   logic [7:0]  fwrev_r, fwrev_nxt;
   logic [7:0]  crc_r, crc_nxt;
   logic [AW:0] idx_r, idx_nxt;
   logic        vld_r, vld_nxt;
   logic [7:0]  rdata_nxt;
   logic        ack_nxt;
   logic [6:0]  norm_addr;
   logic        hit, in_app, in_ldr, fwr, erase_go;

   always_comb begin
      norm_addr = {NORM_ADDR_HI, strap_r, 1'b0};
      in_app    = (st_r == ST_APP) && (dev_addr_in == norm_addr);
      in_ldr    = (st_r == ST_LOADER || st_r == ST_PROG) && (dev_addr_in == GLOBAL_ADDR);
      hit       = in_app || in_ldr;
      fwr       = in_ldr && wr_in && st_r == ST_PROG && reg_addr_in == REG_FLASH_DATA;
      st_nxt    = st_r;
      tmr_nxt   = tmr_r + 32'h1;
      key_nxt   = key_r;
      fail_nxt  = fail_r;
      faddr_nxt = faddr_r;
      fwrev_nxt = fwrev_r;
      crc_nxt   = crc_r;
      idx_nxt   = idx_r;
      vld_nxt   = 1'b0;
      erase_go  = 1'b0;
      ack_nxt   = hit && (wr_in || rd_in);
      rdata_nxt = 8'h00;
      if (hit && rd_in) begin
         if (fail_r) begin
            rdata_nxt = FAIL_VAL;
         end else begin
            unique case (reg_addr_in)
               REG_FW_REV:   rdata_nxt = fwrev_r;
               REG_ADDR_LSB: rdata_nxt = faddr_r[7:0];
               REG_ADDR_MSB: rdata_nxt = faddr_r[15:8];
               default:      rdata_nxt = 8'h00;
            endcase
         end
      end
      unique case (st_r)
         ST_BOOT: begin
            if (tmr_r >= 32'(BOOT_CYCLES - 1)) begin
               st_nxt = ST_APP;
            end
         end
         ST_APP: begin
            tmr_nxt = '0;
            if (in_app && wr_in && !fail_r && reg_addr_in == REG_FLASH_CTRL && wdata_in == CMD_ENTER) begin
               st_nxt = ST_ENTER;
            end
         end
         ST_ENTER: begin
            key_nxt = 1'b0;
            if (tmr_r >= 32'(ENTER_CYC - 1)) begin
               st_nxt = ST_LOADER;
            end
         end
         ST_LOADER: begin
            tmr_nxt = '0;
            if (in_ldr && wr_in && reg_addr_in == REG_ERASE_KEY) begin
               key_nxt = (wdata_in == ERASE_KEY_VAL);
            end
            if (in_ldr && wr_in && reg_addr_in == REG_FLASH_CTRL && wdata_in == CMD_ENTER && key_r) begin
               st_nxt   = ST_ERASE;
               erase_go = 1'b1;
               key_nxt  = 1'b0;
            end
         end
         ST_ERASE: begin
            if (tmr_r >= 32'(ERASE_CYCLES - 1)) begin
               st_nxt = ST_PROG;
            end
         end
         ST_PROG: begin
            tmr_nxt = '0;
            if (in_ldr && wr_in && reg_addr_in == REG_ADDR_LSB) begin
               faddr_nxt[7:0] = wdata_in;
            end
            if (in_ldr && wr_in && reg_addr_in == REG_ADDR_MSB) begin
               faddr_nxt[15:8] = wdata_in;
            end
            if (fwr) begin
               faddr_nxt = faddr_r + 16'h1;
            end
            if (in_ldr && wr_in && reg_addr_in == REG_FLASH_CTRL && wdata_in == CMD_DONE) begin
               st_nxt  = ST_CRC;
               idx_nxt = '0;
               crc_nxt = 8'h00;
            end
         end
         ST_CRC: begin
            tmr_nxt = '0;
            vld_nxt = idx_r < (AW+1)'(APP_BYTES);
            if (vld_nxt) begin
               idx_nxt = idx_r + 1'b1;
            end
            if (vld_r) begin
               crc_nxt = crc8(crc_r, fl.rd_data);
               if (idx_r == (AW+1)'(1)) begin
                  fwrev_nxt = fl.rd_data;
               end
            end
            if (!vld_r && !vld_nxt) begin
               fail_nxt = (crc_r != 8'h00);
               st_nxt   = ST_BOOT;
            end
         end
         default: begin
            st_nxt = ST_BOOT;
         end
      endcase
   end

   // only bytes that land inside the application array reach the flash
   assign fl.wr_en   = fwr && ({1'b0, faddr_r} < 17'(APP_BYTES));
   assign fl.wr_addr = faddr_r[AW-1:0];
   assign fl.wr_data = wdata_in;
   assign fl.erase   = erase_go;
   assign fl.rd_addr = idx_r[AW-1:0];

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         st_r       <= ST_BOOT;
         tmr_r      <= '0;
         key_r      <= 1'b0;
         fail_r     <= 1'b0;
         faddr_r    <= '0;
         fwrev_r    <= '0;
         crc_r      <= '0;
         idx_r      <= '0;
         vld_r      <= 1'b0;
         rdata_out  <= '0;
         ack_out    <= 1'b0;
         loader_out <= 1'b0;
         busy_out   <= 1'b0;
         fail_out   <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         tmr_r      <= tmr_nxt;
         key_r      <= key_nxt;
         fail_r     <= fail_nxt;
         faddr_r    <= faddr_nxt;
         fwrev_r    <= fwrev_nxt;
         crc_r      <= crc_nxt;
         idx_r      <= idx_nxt;
         vld_r      <= vld_nxt;
         rdata_out  <= rdata_nxt;
         ack_out    <= ack_nxt;
         loader_out <= (st_nxt == ST_LOADER || st_nxt == ST_PROG || st_nxt == ST_ERASE);
         busy_out   <= (st_nxt == ST_BOOT || st_nxt == ST_ENTER || st_nxt == ST_ERASE || st_nxt == ST_CRC);
         fail_out   <= fail_nxt;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_app_bound_only: assert property (fl.wr_en |-> {1'b0, faddr_r} < 17'(APP_BYTES))
      else $error("flash write outside application region");
   a_norm_addr_hit: assert property ((st_r == ST_APP && rd_in && dev_addr_in == norm_addr) |=> ack_out)
      else $error("normal address not answered");
   a_loader_global_only: assert property ((st_r == ST_PROG && (wr_in || rd_in) && dev_addr_in != GLOBAL_ADDR)
      |=> !ack_out)
      else $error("loader answered non-global address");
   a_enter_to_loader: assert property ((st_r == ST_APP && st_nxt == ST_ENTER) |=> ##[15:16] st_r == ST_LOADER)
      else $error("loader not reached after entry");
   a_erase_needs_key: assert property ((st_r == ST_LOADER && st_nxt == ST_ERASE) |-> key_r)
      else $error("erase without key");
   a_erase_starts_flash: assert property ($rose(st_r == ST_ERASE) |-> fl.busy)
      else $error("flash erase not started");
   a_data_inc_pos: assert property (fwr |=> faddr_r == $past(faddr_r) + 16'h1)
      else $error("flash position did not advance");
   a_fail_reads_ff: assert property ((fail_r && rd_in && hit) |=> rdata_out == FAIL_VAL)
      else $error("failed device read not 0xFF");
   a_crc_reboots: assert property ($rose(st_r == ST_CRC) |-> ##CRC_LEN st_r == ST_BOOT)
      else $error("check pass did not end in reboot");
endmodule // ffu_seq
`default_nettype wire

/* logic/ffu_pkg.sv */
// flash update sequencer constants: register offsets, commands, timing, states
// assumes a 125 MHz core clock and an 8-bit register port behind the serial target
package ffu_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_FW_REV     = 8'h41;
   localparam logic [7:0] REG_FLASH_CTRL = 8'h60;
   localparam logic [7:0] REG_ERASE_KEY  = 8'h61;
   localparam logic [7:0] REG_ADDR_LSB   = 8'h62;
   localparam logic [7:0] REG_ADDR_MSB   = 8'h63;
   localparam logic [7:0] REG_FLASH_DATA = 8'h64;
   // ----------------------------------------------------------------
   // commands, keys and addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_ENTER      = 8'hC1;
   localparam logic [7:0] CMD_DONE       = 8'h08;
   localparam logic [7:0] ERASE_KEY_VAL  = 8'hDB;
   localparam logic [7:0] FAIL_VAL       = 8'hFF;
   localparam logic [7:0] ERASED_VAL     = 8'hFF;
   localparam logic [7:0] CRC_POLY       = 8'h07;
   localparam logic [6:0] GLOBAL_ADDR    = 7'h7F;
   localparam logic [1:0] NORM_ADDR_HI   = 2'h1;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_KHZ       = 125000;
   localparam int unsigned BOOT_MS       = 30;
   localparam int unsigned ERASE_MS      = 1000;
   localparam int unsigned BOOT_CYC      = BOOT_MS * CLK_KHZ;
   localparam int unsigned ERASE_CYC     = ERASE_MS * CLK_KHZ;
   localparam int unsigned ENTER_CYC     = 16;
   localparam int unsigned APP_BYTES_DEF = 256;
   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_BOOT   = 3'b000,
      ST_APP    = 3'b001,
      ST_ENTER  = 3'b010,
      ST_LOADER = 3'b011,
      ST_ERASE  = 3'b100,
      ST_PROG   = 3'b101,
      ST_CRC    = 3'b110
   } ffu_state_t;
endpackage

/* logic/ffu_flash_if.sv */
// link between the sequencer and the application flash array
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface ffu_flash_if #(parameter int AW = 8);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [7:0]    wr_data;
   logic          erase;
   logic          busy;
   logic [AW-1:0] rd_addr;
   logic [7:0]    rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, erase, rd_addr, input busy, rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, erase, rd_addr, output busy, rd_data);
endinterface
`default_nettype wire

/* logic/ffu_flash.sv */
// application flash array: byte write, synchronous read, whole-array erase
// assumes the sequencer never writes while an erase is running
`timescale 1ns/100ps
`default_nettype none
module ffu_flash #(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic  clk_in,
   input  wire logic  resetn_in,
   ffu_flash_if.mem   fl
);
   import ffu_pkg::*;
   logic [7:0]    mem_r [DEPTH];
   logic          busy_r, busy_nxt;
   logic [AW-1:0] cnt_r, cnt_nxt;
   logic [7:0]    rd_r;

   // ----------------------------------------------------------------
   // erase walker
   // ----------------------------------------------------------------
   always_comb begin
      busy_nxt = busy_r;
      cnt_nxt  = cnt_r;
      if (fl.erase && !busy_r) begin
         busy_nxt = 1'b1;
         cnt_nxt  = '0;
      end else if (busy_r) begin
         cnt_nxt = cnt_r + 1'b1;
         if (cnt_r == AW'(DEPTH - 1)) begin
            busy_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         busy_r <= 1'b0;
         cnt_r  <= '0;
      end else begin
         busy_r <= busy_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (busy_r) begin
         mem_r[cnt_r] <= ERASED_VAL;
      end else if (fl.wr_en) begin
         mem_r[fl.wr_addr] <= fl.wr_data;
      end
      rd_r <= mem_r[fl.rd_addr];
   end

   assign fl.busy    = busy_r;
   assign fl.rd_data = rd_r;
endmodule // ffu_flash
`default_nettype wire

/* logic/ffu_README_unused.sv */
// holds no logic; keeps the design folder layout fixed
// assumes nothing of its surroundings
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* verification/ffu_host_model.sv */
// serial host stand-in: drives one-cycle register strobes
// assumes strobes are sampled on the rising edge of clk_in
`timescale 1ns/100ps
`default_nettype none
module ffu_host_model (
   input  wire logic       clk_in,
   output logic      [6:0] dev_addr_out,
   output logic      [7:0] reg_addr_out,
   output logic      [7:0] wdata_out,
   output logic            wr_out,
   output logic            rd_out
);
   initial begin
      dev_addr_out = 7'h00;
      reg_addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic access(input logic w, input logic [6:0] d, input logic [7:0] r, input logic [7:0] v);
      @(posedge clk_in);
      dev_addr_out <= d;
      reg_addr_out <= r;
      wdata_out <= v;
      wr_out <= w;
      rd_out <= !w;
   endtask
   // released address and data lines show the inverse of their last value, strobes go low
   task automatic release_bus(input int n);
      repeat (n) begin
         @(posedge clk_in);
         wr_out <= 1'b0;
         rd_out <= 1'b0;
         dev_addr_out <= ~dev_addr_out;
         reg_addr_out <= ~reg_addr_out;
         wdata_out <= ~wdata_out;
      end
      #2;
   endtask
endmodule // ffu_host_model
`default_nettype wire

/* verification/i2c_firmware_flash_update_tb.sv */
// self-checking bench of the flash update sequencer
// assumes shortened boot, erase and array size parameters
`timescale 1ns/100ps
`default_nettype none
module i2c_firmware_flash_update_tb;
   import ffu_pkg::*;
   localparam int unsigned BOOT_N = 50;
   localparam int unsigned ERASE_N = 300;
   localparam int unsigned APP_N = 16;
   typedef struct packed {logic ca; logic a; logic cd; logic [7:0] d;} ffu_exp_t;
   logic       clk_in, resetn_in, wr, rd, ack, loader, busy, fail, pend;
   logic [3:0] strap;
   logic [6:0] dev_addr, norm;
   logic [7:0] reg_addr, wdata, rdata, lfsr, rev_exp;
   logic [7:0] img [APP_N];
   ffu_exp_t   exp_q [$];
   ffu_exp_t   e;
   int         miscompares, n_checks, cycles;

   ffu_host_model host (.clk_in(clk_in), .dev_addr_out(dev_addr), .reg_addr_out(reg_addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
   ffu_seq #(.BOOT_CYCLES(BOOT_N), .ERASE_CYCLES(ERASE_N), .APP_BYTES(APP_N)) dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .addr_strap_pins_in(strap), .dev_addr_in(dev_addr),
      .reg_addr_in(reg_addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .ack_out(ack), .loader_out(loader), .busy_out(busy), .fail_out(fail));

   always #4 clk_in = ~clk_in;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int b = 0; b < 8; b++) x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
      return x;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      n_checks++;
      if (seen !== expv) begin
         miscompares++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [6:0] d, input logic [7:0] r, input logic [7:0] v, input logic a);
      exp_q.push_back({1'b1, a, 1'b0, 8'h00});
      host.access(1'b1, d, r, v);
   endtask
   task automatic rd_reg(input logic [6:0] d, input logic [7:0] r, input logic a, input logic [7:0] v);
      exp_q.push_back({1'b1, a, 1'b1, v});
      host.access(1'b0, d, r, 8'h00);
   endtask
   task automatic wait_busy_low();
      for (int i = 0; i < 1000 && busy !== 1'b0; i++) host.release_bus(1);
   endtask
   task automatic reset_dut();
      resetn_in <= 1'b0;
      rev_exp = 8'h00;
      host.release_bus(10);
      resetn_in <= 1'b1;
      host.release_bus(2);
      check({7'h00, busy}, 8'h01);
   endtask
   // ---------------------------------------------------------------
   // response monitor: one answer in the cycle after each strobe
   // ---------------------------------------------------------------
   always @(negedge clk_in) begin
      if (pend && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e.ca) check({7'h00, ack}, {7'h00, e.a});
         if (e.cd) check(rdata, e.d);
      end
      pend = wr | rd;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ---------------------------------------------------------------
   // one full update pass, good or corrupt image
   // ---------------------------------------------------------------
   task automatic update(input logic good);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < APP_N - 1; i++) begin
         lfsr = lfsr_next(lfsr);
         img[i] = lfsr;
         c = crc8(c, lfsr);
      end
      img[APP_N-1] = good ? c : c ^ 8'h01;
      rd_reg(norm, REG_FW_REV, 1'b1, rev_exp);
      wr_reg(norm, REG_FLASH_CTRL, CMD_ENTER, 1'b1);
      host.release_bus(1);
      for (int i = 0; i < 40 && loader !== 1'b1; i++) host.release_bus(1);
      check({7'h00, loader}, 8'h01);
      host.release_bus(30);
      wr_reg(norm, REG_FLASH_CTRL, CMD_ENTER, 1'b0);
      wr_reg(GLOBAL_ADDR, REG_FLASH_CTRL, CMD_ENTER, 1'b1);
      wr_reg(GLOBAL_ADDR, REG_ERASE_KEY, 8'hDA, 1'b1);
      wr_reg(GLOBAL_ADDR, REG_FLASH_CTRL, CMD_ENTER, 1'b1);
      host.release_bus(3);
      check({7'h00, busy}, 8'h00);
      wr_reg(GLOBAL_ADDR, REG_ERASE_KEY, ERASE_KEY_VAL, 1'b1);
      wr_reg(GLOBAL_ADDR, REG_FLASH_CTRL, CMD_ENTER, 1'b1);
      host.release_bus(3);
      check({7'h00, busy}, 8'h01);
      wait_busy_low();
      wr_reg(GLOBAL_ADDR, REG_ADDR_LSB, 8'h00, 1'b1);
      wr_reg(GLOBAL_ADDR, REG_ADDR_MSB, 8'h00, 1'b1);
      wr_reg(norm, REG_FLASH_DATA, 8'h5A, 1'b0);
      for (int i = 0; i < APP_N; i++) begin
         wr_reg(GLOBAL_ADDR, REG_FLASH_DATA, img[i], 1'b1);
         if (i < APP_N / 2) host.release_bus(1);
      end
      wr_reg(GLOBAL_ADDR, REG_FLASH_DATA, 8'hA5, 1'b1);
      rd_reg(GLOBAL_ADDR, REG_ADDR_LSB, 1'b1, 8'(APP_N + 1));
      wr_reg(GLOBAL_ADDR, REG_FLASH_CTRL, CMD_DONE, 1'b1);
      host.release_bus(3);
      wait_busy_low();
      check({7'h00, loader}, 8'h00);
      check({7'h00, fail}, {7'h00, !good});
      rd_reg(norm, REG_FW_REV, 1'b1, good ? img[0] : FAIL_VAL);
      rd_reg(norm, REG_ADDR_MSB, 1'b1, good ? 8'h00 : FAIL_VAL);
      host.release_bus(2);
      if (good) begin
         rev_exp = img[0];
      end
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      resetn_in = 1'b0;
      pend = 1'b0;
      miscompares = 0;
      n_checks = 0;
      cycles = 0;
      lfsr = 8'h20;
      lfsr = lfsr_next(lfsr);
      strap = lfsr[3:0];
      norm = {NORM_ADDR_HI, strap, 1'b0};
      reset_dut();
      rd_reg(norm, REG_FW_REV, 1'b0, 8'h00);
      host.release_bus(1);
      wait_busy_low();
      rd_reg(norm, REG_FW_REV, 1'b1, 8'h00);
      rd_reg(norm | 7'h01, REG_FW_REV, 1'b0, 8'h00);
      rd_reg(GLOBAL_ADDR, REG_FW_REV, 1'b0, 8'h00);
      host.release_bus(2);
      $display("test boot_and_address done");
      update(1'b1);
      $display("test good_update done");
      update(1'b0);
      $display("test corrupt_update done");
      // new strap levels across the restart so the address decode follows the pins
      lfsr = lfsr_next(lfsr);
      strap <= strap ^ (lfsr[3:0] | 4'h1);
      reset_dut();
      norm = {NORM_ADDR_HI, strap, 1'b0};
      check({7'h00, fail}, 8'h00);
      wait_busy_low();
      rd_reg(norm, REG_FLASH_CTRL, 1'b1, 8'h00);
      host.release_bus(2);
      update(1'b1);
      $display("test restart done");
      give_verdict();
   end
endmodule // i2c_firmware_flash_update_tb
`default_nettype wire
